// ---- verilog/reconfig_pkg.sv ----
// Package of constants for the transceiver reconfiguration loader
// Notes on behaviour
// R1: Word index counts up by one, wraps
// R2: Wrap from last index marks load end
// R3: Index-change pulse after each full word
// R4: One-cycle index clear returns index to zero
// R5: Data valid with every write strobe
// R6: Controller reset clears all control registers; code acts on it only while mode_sel is MODE_CHANNEL
// R7: Controller reset synchronized to clock outside
// R8: Done flag set at end, cleared on restart
// R9: Offset cancellation once per power cycle
// R10: Later reset does not rerun cancellation
// R11: Reset from power-up postpones cancellation start
// R12: Reset during cancellation aborts and restarts it
// R13: Isolate inputs, step states, cancel buffer offset
// R14: Busy low first cycle, high second
// R15: Cancellation busy falls on success or on controller reset
// R16: Cancellation lasts 16 clock cycles
// R17: Powerdown held low during cancellation
// R18: Transmitter-only configurations skip cancellation
// R19: Dedicated outbound and inbound channel buses
// R20: Mode 001 channel, 000 analog default
// R21: Write only while idle, one-cycle strobe
// R22: Busy during word write, strobes ignored
package reconfig_pkg;
   localparam int DATA_W = 16;
   localparam int ADDR_W = 6;
   localparam logic [ADDR_W-1:0] LAST_INDEX = 6'h3f;
   localparam logic [ADDR_W-1:0] INDEX_RESET = 6'h00;
   localparam logic [2:0] MODE_ANALOG = 3'h0;
   localparam logic [2:0] MODE_CHANNEL = 3'h1;
   localparam int CLK_PERIOD_NS = 100;
   localparam int OC_TIME_NS = 1600;
   localparam int OC_CYCLES = OC_TIME_NS / CLK_PERIOD_NS;
   localparam int OC_STEP_CYCLES = OC_CYCLES - 2;
   localparam logic [4:0] OC_CNT_RESET = 5'h00;
   localparam int WRITE_CYCLES = 2;
   localparam int BUS_OUT_W = 20;
   localparam int BUS_IN_W = 17;
   localparam logic [1:0] BUS_OP_IDLE = 2'h0;
   localparam logic [1:0] BUS_OP_ISOLATE = 2'h1;
   localparam logic [1:0] BUS_OP_STEP = 2'h2;
   localparam logic [1:0] BUS_OP_BUFFER = 2'h3;
   localparam int FIFO_DEPTH = 32;
   typedef enum logic [5:0] {
      ST_POWERUP = 6'b00_0001,
      ST_ISOLATE = 6'b00_0010,
      ST_STEP = 6'b00_0100,
      ST_BUFFER = 6'b00_1000,
      ST_IDLE = 6'b01_0000,
      ST_WRITE = 6'b10_0000
   } loader_state_e;
endpackage

// ---- verilog/reconfig_if.sv ----
// Interface joining user logic and the reconfiguration loader
`timescale 1ns/1ps
`default_nettype none
interface reconfig_if;
   import reconfig_pkg::*;
   logic [2:0] mode_sel;
   logic write_strobe;
   logic [DATA_W-1:0] cfg_data;
   logic index_clear;
   logic ctrl_reset;
   logic powerdown;
   logic busy;
   logic [ADDR_W-1:0] word_index;
   logic index_changed;
   logic load_done;
   modport loader (
      input mode_sel, write_strobe, cfg_data, index_clear, ctrl_reset,
      input powerdown,
      output busy, word_index, index_changed, load_done
   );
   modport user (
      output mode_sel, write_strobe, cfg_data, index_clear, ctrl_reset,
      output powerdown,
      input busy, word_index, index_changed, load_done
   );
endinterface
`default_nettype wire

// ---- verilog/word_fifo.sv ----
// Word FIFO with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 32
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0] wr_q;
   logic [PW-1:0] rd_q;
   logic [PW:0] count_q;
   logic push;
   logic pop;
   assign in_ready = (count_q != (PW+1)'(DEPTH));
   assign out_valid = (count_q != '0);
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;
   assign out_data = mem[rd_q];
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_q] <= in_data;
      end
   end
   always_ff @(posedge clk) begin
      if (!rstn) begin
         wr_q <= '0;
         rd_q <= '0;
         count_q <= '0;
      end else begin
         if (push) begin
            wr_q <= wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= rd_q + 1'b1;
         end
         count_q <= count_q + (PW+1)'(push) - (PW+1)'(pop);
      end
   end
endmodule
`default_nettype wire

// ---- verilog/reconfig_loader.sv ----
// Loader end: word streaming, index tracking and offset cancellation
`timescale 1ns/1ps
`default_nettype none
module reconfig_loader (
   input wire logic clk,
   input wire logic rstn,
   reconfig_if.loader link,
   input wire logic rx_present,
   output logic [reconfig_pkg::BUS_OUT_W-1:0] to_chan,
   input wire logic [reconfig_pkg::BUS_IN_W-1:0] from_chan,
   output logic rx_isolate
);
   import reconfig_pkg::*;
   // ---------------------------------------------
   // State and counters
   // ---------------------------------------------
   loader_state_e state_q;
   logic oc_done_q;
   logic [4:0] oc_cnt_q;
   logic [1:0] wr_cnt_q;
   logic [ADDR_W-1:0] index_q;
   logic [DATA_W-1:0] word_q;
   logic changed_q;
   logic done_q;
   logic [BUS_OUT_W-1:0] to_chan_q;
   logic chan_mode;
   logic ctrl_rst;
   logic start_wr;
   assign chan_mode = (link.mode_sel == MODE_CHANNEL);
   assign ctrl_rst = link.ctrl_reset & chan_mode; // [R6] [R7]
   // [R21] [R22]
   assign start_wr = (state_q == ST_IDLE) & link.write_strobe & chan_mode;
   // ---------------------------------------------
   // Sequencer
   // ---------------------------------------------
   always_ff @(posedge clk) begin
      if (!rstn) begin
         state_q <= ST_POWERUP;
         oc_cnt_q <= OC_CNT_RESET;
         wr_cnt_q <= '0;
      end else if (ctrl_rst) begin
         // [R10] [R11] [R12]
         state_q <= oc_done_q ? ST_IDLE : ST_POWERUP;
         oc_cnt_q <= OC_CNT_RESET;
         wr_cnt_q <= '0;
      end else begin
         case (state_q)
            ST_POWERUP: begin
               // [R9] [R18]
               state_q <= (oc_done_q | !rx_present) ? ST_IDLE : ST_ISOLATE;
            end
            ST_ISOLATE: begin
               state_q <= ST_STEP; // [R13]
            end
            ST_STEP: begin
               oc_cnt_q <= oc_cnt_q + 5'h01;
               if (oc_cnt_q == 5'(OC_STEP_CYCLES - 1)) begin // [R16]
                  state_q <= ST_BUFFER;
               end
            end
            ST_BUFFER: begin
               if (from_chan[BUS_IN_W-1]) begin // [R15]
                  state_q <= ST_IDLE;
               end
            end
            ST_IDLE: begin
               if (start_wr) begin
                  state_q <= ST_WRITE;
                  wr_cnt_q <= '0;
               end
            end
            ST_WRITE: begin
               wr_cnt_q <= wr_cnt_q + 2'h1;
               if (wr_cnt_q == 2'(WRITE_CYCLES - 1)) begin
                  state_q <= ST_IDLE;
               end
            end
            default: state_q <= ST_POWERUP;
         endcase
      end
   end
   // Cancellation done, kept across controller reset
   always_ff @(posedge clk) begin
      if (!rstn) begin
         oc_done_q <= 1'b0;
      end else if (state_q == ST_POWERUP && !rx_present) begin
         oc_done_q <= 1'b1; // [R18]
      end else if (state_q == ST_BUFFER && from_chan[BUS_IN_W-1]
                   && !ctrl_rst) begin
         oc_done_q <= 1'b1; // [R9] [R10]
      end
   end
   // ---------------------------------------------
   // Word index, change strobe and done flag
   // ---------------------------------------------
   always_ff @(posedge clk) begin
      if (!rstn || ctrl_rst) begin
         index_q <= INDEX_RESET;
         changed_q <= 1'b0;
         done_q <= 1'b0;
         word_q <= '0;
      end else begin
         changed_q <= 1'b0;
         if (start_wr) begin
            word_q <= link.cfg_data; // [R5]
            if (index_q == INDEX_RESET) begin
               done_q <= 1'b0; // [R8]
            end
         end
         if (state_q == ST_WRITE && wr_cnt_q == 2'(WRITE_CYCLES - 1)) begin
            changed_q <= 1'b1; // [R3]
            if (index_q == LAST_INDEX) begin
               index_q <= INDEX_RESET; // [R1] [R2]
               done_q <= 1'b1; // [R8]
            end else begin
               index_q <= index_q + 6'h01; // [R1]
            end
         end else if (link.index_clear) begin
            index_q <= INDEX_RESET; // [R4]
         end
      end
   end
   // ---------------------------------------------
   // Channel buses
   // ---------------------------------------------
   always_ff @(posedge clk) begin
      if (!rstn) begin
         to_chan_q <= '0;
      end else begin
         case (state_q)
            ST_ISOLATE: to_chan_q <= {BUS_OP_ISOLATE, 18'h0_0000}; // [R13]
            ST_STEP: to_chan_q <= {BUS_OP_STEP, 13'h0000, oc_cnt_q};
            ST_BUFFER: to_chan_q <= {BUS_OP_BUFFER, 18'h0_0000};
            ST_WRITE: to_chan_q <= {BUS_OP_IDLE, index_q[1:0], word_q};
            default: to_chan_q <= '0;
         endcase
      end
   end
   assign to_chan = to_chan_q; // [R19]
   assign rx_isolate = (state_q == ST_ISOLATE) | (state_q == ST_STEP)
                       | (state_q == ST_BUFFER);
   // [R14] [R15] [R22]
   assign link.busy = (state_q != ST_IDLE) & (state_q != ST_POWERUP);
   assign link.word_index = index_q;
   assign link.index_changed = changed_q;
   assign link.load_done = done_q;
endmodule
`default_nettype wire

// ---- verilog/reconfig_user.sv ----
// User end: feeds configuration words from a FIFO to the loader
`timescale 1ns/1ps
`default_nettype none
module reconfig_user (
   input wire logic clk,
   input wire logic rstn,
   reconfig_if.user link,
   input wire logic word_valid,
   output logic word_ready,
   input wire logic [reconfig_pkg::DATA_W-1:0] word_data,
   input wire logic clear_req,
   input wire logic reset_req,
   input wire logic powerdown_req,
   output logic [reconfig_pkg::ADDR_W-1:0] index,
   output logic done
);
   import reconfig_pkg::*;
   logic f_valid;
   logic f_ready;
   logic [DATA_W-1:0] f_data;
   logic strobe_q;
   logic [DATA_W-1:0] data_q;
   logic clear_q;
   logic clear_prev_q;
   logic rst_meta_q;
   logic rst_sync_q;
   logic pending_q;
   logic [ADDR_W-1:0] index_q;
   logic done_q;
   word_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) fifo (
      .clk(clk),
      .rstn(rstn),
      .in_valid(word_valid),
      .in_ready(word_ready),
      .in_data(word_data),
      .out_valid(f_valid),
      .out_ready(f_ready),
      .out_data(f_data)
   );
   // ---------------------------------------------
   // Write strobe issue
   // ---------------------------------------------
   // [R21]
   assign f_ready = !link.busy & !strobe_q & !pending_q & !rst_sync_q;
   always_ff @(posedge clk) begin
      if (!rstn) begin
         strobe_q <= 1'b0;
         data_q <= '0;
         pending_q <= 1'b0;
      end else begin
         strobe_q <= f_valid & f_ready; // [R21]
         if (f_valid & f_ready) begin
            data_q <= f_data; // [R5]
         end
         if (strobe_q) begin
            pending_q <= 1'b1;
         end else if (link.index_changed || rst_sync_q) begin
            pending_q <= 1'b0;
         end
      end
   end
   // ---------------------------------------------
   // Clear pulse and synchronized reset
   // ---------------------------------------------
   always_ff @(posedge clk) begin
      if (!rstn) begin
         clear_q <= 1'b0;
         clear_prev_q <= 1'b0;
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
         index_q <= '0;
         done_q <= 1'b0;
      end else begin
         clear_prev_q <= clear_req;
         clear_q <= clear_req & !clear_prev_q; // [R4]
         rst_meta_q <= reset_req;
         rst_sync_q <= rst_meta_q; // [R7]
         index_q <= link.word_index;
         done_q <= link.load_done;
      end
   end
   assign link.mode_sel = MODE_CHANNEL; // [R20]
   assign link.write_strobe = strobe_q;
   assign link.cfg_data = data_q;
   assign link.index_clear = clear_q;
   assign link.ctrl_reset = rst_sync_q;
   assign link.powerdown = powerdown_req & !link.busy; // [R17]
   assign index = index_q;
   assign done = done_q;
endmodule
`default_nettype wire

// ---- verification/reconfig_loader_asserts.sv ----
// Checker on the link between user end and loader
`timescale 1ns/1ps
`default_nettype none
module reconfig_loader_asserts (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [2:0] mode_sel,
   input wire logic write_strobe,
   input wire logic index_clear,
   input wire logic ctrl_reset,
   input wire logic powerdown,
   input wire logic busy,
   input wire logic [reconfig_pkg::ADDR_W-1:0] word_index,
   input wire logic index_changed,
   input wire logic load_done
);
   import reconfig_pkg::*;
   logic [4:0] run_q;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   // Busy run length
   always_ff @(posedge clk) begin
      if (!rstn || !busy) begin
         run_q <= 5'h00;
      end else begin
         run_q <= run_q + 5'h01;
      end
   end
   a_index_step: assert property (index_changed |->
      word_index == $past(word_index) + 6'h01) else $error("bad step");
   a_index_hold: assert property ($changed(word_index) |->
      (index_changed || word_index == INDEX_RESET)) else $error("stray");
   a_done_wrap: assert property (
      (index_changed && word_index == INDEX_RESET) |-> ##[0:1] load_done)
      else $error("done not set");
   a_done_clear: assert property (
      (write_strobe && !busy && word_index == INDEX_RESET && load_done)
      |-> ##[1:3] !load_done) else $error("done not cleared");
   a_busy_first: assert property (
      !$past(rstn) |-> !busy ##1 busy) else $error("busy start");
   a_busy_length: assert property (
      ($fell(busy) && !$past(ctrl_reset)) |->
      (run_q == OC_CYCLES || run_q == WRITE_CYCLES)) else $error("busy len");
   a_write_busy: assert property (
      (write_strobe && !busy && !ctrl_reset && mode_sel == MODE_CHANNEL)
      |=> busy [*2] ##1 (!busy && index_changed)) else $error("write");
   a_clear_index: assert property (
      (index_clear && !busy) |=> word_index == INDEX_RESET)
      else $error("clear");
   a_reset_clears: assert property (ctrl_reset |=>
      (word_index == INDEX_RESET && !load_done && !index_changed))
      else $error("reset");
   a_pd_gated: assert property (busy |-> !powerdown)
      else $error("powerdown");
endmodule
`default_nettype wire

// ---- verification/test_transceiver_reconfig_loader.sv ----
// Testbench joining user end and loader end
`timescale 1ns/1ps
`default_nettype none
module test_transceiver_reconfig_loader;
   import reconfig_pkg::*;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic word_valid = 1'b0;
   logic word_ready;
   logic [DATA_W-1:0] word_data = 16'h0000;
   logic clear_req = 1'b0;
   logic reset_req = 1'b0;
   logic powerdown_req = 1'b0;
   logic [ADDR_W-1:0] index;
   logic done;
   logic rx_isolate;
   int num_errors = 0;
   int total_checks = 0;
   int cycles = 0;
   int pulses = 0;
   int clears = 0;
   int refused = 0;
   reconfig_if link ();
   reconfig_user reconfig_user_i (.clk(clk), .rstn(rstn), .link(link),
      .word_valid(word_valid), .word_ready(word_ready),
      .word_data(word_data), .clear_req(clear_req), .reset_req(reset_req),
      .powerdown_req(powerdown_req), .index(index), .done(done));
   reconfig_loader reconfig_loader_i (.clk(clk), .rstn(rstn), .link(link),
      .rx_present(1'b1), .to_chan(), .from_chan({1'b1, 16'h0000}),
      .rx_isolate(rx_isolate));
   reconfig_loader_asserts reconfig_loader_asserts_i (.clk(clk),
      .rstn(rstn), .mode_sel(link.mode_sel),
      .write_strobe(link.write_strobe), .index_clear(link.index_clear),
      .ctrl_reset(link.ctrl_reset), .powerdown(link.powerdown),
      .busy(link.busy), .word_index(link.word_index),
      .index_changed(link.index_changed), .load_done(link.load_done));
   always #50 clk = ~clk;
   // ----------------------------------------
   // Monitor and timeout
   // ----------------------------------------
   always @(posedge clk) begin
      cycles++;
      if (link.index_changed === 1'b1) pulses++;
      if (link.index_clear === 1'b1) clears++;
      if (cycles == 5000) begin
         num_errors++;
         close_out();
      end
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #10;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic close_out();
      $display("checks %0d, errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic busy_run(output int n);
      int w;
      n = 0;
      w = 0;
      while (link.busy !== 1'b1 && w < 100) begin tick(1); w++; end
      while (link.busy === 1'b1 && n < 100) begin tick(1); n++; end
   endtask
   task automatic push(input logic [DATA_W-1:0] d);
      word_valid = 1'b1;
      word_data = d;
      while (word_ready !== 1'b1) begin refused++; tick(1); end
      tick(1);
   endtask
   task automatic wait_index(input logic [ADDR_W-1:0] v);
      for (int w = 0; w < 100 && index !== v; w++) tick(1);
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_powerup();
      int n;
      check(link.busy, 1'b0);
      tick(1);
      check(link.busy, 1'b1);
      check(rx_isolate, 1'b1);
      busy_run(n);
      check(n, OC_CYCLES);
      check(rx_isolate, 1'b0);
   endtask
   task automatic t_load();
      pulses = 0;
      for (int i = 0; i <= int'(LAST_INDEX); i++) push(16'(16'ha500 + i));
      word_valid = 1'b0;
      for (int w = 0; w < 1000 && done !== 1'b1; w++) tick(1);
      check(done, 1'b1);
      check(index, INDEX_RESET);
      check(pulses, int'(LAST_INDEX) + 1);
      check(refused > 0, 1'b1);
   endtask
   task automatic t_clear();
      push(16'h1234);
      word_valid = 1'b0;
      wait_index(6'h01);
      check(done, 1'b0);
      check(index, 6'h01);
      clear_req = 1'b1;
      tick(3);
      clear_req = 1'b0;
      check(index, INDEX_RESET);
      check(clears, 1);
   endtask
   task automatic t_ctrl();
      int hi;
      hi = 0;
      push(16'h0001);
      push(16'h0002);
      word_valid = 1'b0;
      wait_index(6'h02);
      reset_req = 1'b1;
      tick(4);
      reset_req = 1'b0;
      tick(3);
      check(index, INDEX_RESET);
      for (int i = 0; i < 30; i++) begin
         if (link.busy === 1'b1) hi++;
         tick(1);
      end
      check(hi, 0);
   endtask
   task automatic t_abort();
      int n;
      rstn = 1'b0;
      tick(3);
      rstn = 1'b1;
      powerdown_req = 1'b1;
      tick(6);
      reset_req = 1'b1;
      tick(4);
      reset_req = 1'b0;
      check(link.busy, 1'b0);
      busy_run(n);
      check(n, OC_CYCLES);
      check(link.powerdown, 1'b1);
      powerdown_req = 1'b0;
   endtask
   initial begin
      tick(3);
      rstn = 1'b1;
      t_powerup();
      t_load();
      t_clear();
      t_ctrl();
      t_abort();
      close_out();
   end
endmodule
`default_nettype wire
